// ### core/pdr_pkg.sv
// Shared constants and types for the PHY power and cable diagnostic register bank.
package pdr_pkg;

    // Register port geometry.
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;

    // Register offsets.
    localparam logic [ADDR_W-1:0] OFS_BACKOFF    = 9'h0ae;
    localparam logic [ADDR_W-1:0] OFS_REGULATOR  = 9'h0d0;
    localparam logic [ADDR_W-1:0] OFS_EST        = 9'h155;
    localparam logic [ADDR_W-1:0] OFS_DIAG_MAIN  = 9'h170;
    localparam logic [ADDR_W-1:0] OFS_DIAG_PULSE = 9'h171;

    // Field positions.
    localparam int BO_LSB           = 6;
    localparam int BO_MSB           = 8;
    localparam int REG_PD_BIT       = 15;
    localparam int EST_TRIG_BIT     = 15;
    localparam int EST_RES_LSB      = 4;
    localparam int EST_RES_MSB      = 11;
    localparam int EST_AVG_MSB      = 2;
    localparam int DG_CROSS_DIS_BIT = 14;
    localparam int DG_TX_BYP_BIT    = 13;
    localparam int DG_RX_BYP_BIT    = 12;
    localparam int DG_KEEP_BIT      = 11;
    localparam int DG_AVG_LSB       = 8;
    localparam int DG_AVG_MSB       = 10;
    localparam int PULSE_MSB        = 3;

    // Values after reset and fixed read values.
    localparam logic [15:0] BO_FIXED_RD     = 16'h8020;
    localparam logic [2:0]  BO_RST          = 3'h0;
    localparam logic [14:0] REG_RSVD_RST    = 15'h0000;
    localparam logic [2:0]  EST_AVG_RST     = 3'h1;
    localparam logic [7:0]  EST_RES_RST     = 8'h00;
    localparam logic        DG_KEEP_RST     = 1'b1;
    localparam logic [2:0]  DG_AVG_RST      = 3'h6;
    localparam logic [2:0]  DG_AVG_RSVD     = 3'h7;
    localparam logic [2:0]  DG_AVG_MAX      = 3'h6;
    localparam logic [6:0]  DG_AVG_CYC_RST  = 7'h40;
    localparam logic [3:0]  PULSE_RST       = 4'hc;
    localparam logic [11:0] PULSE_RSVD_RST  = 12'hc85;

    // Register port request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } pdr_bus_req_t;

    // Reflectometry setup handed to the analog engine.
    typedef struct packed {
        logic       cross_dis;
        logic       tx_byp;
        logic [2:0] avg_code;
        logic [3:0] pulse;
    } pdr_diag_cfg_t;

    typedef enum logic {
        PAIR_TX = 1'b0,
        PAIR_RX = 1'b1
    } pdr_pair_t;

    typedef enum logic [1:0] {
        EST_IDLE = 2'b00,
        EST_BUSY = 2'b01
    } pdr_est_state_t;

endpackage : pdr_pkg

// ### core/pdr_sc_bit.sv
// Self-clearing control bit where a set always wins over a clear.
`timescale 1ns/1ps
module pdr_sc_bit (
    // Clock and reset.
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    // Control.
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      q_out
);
    logic q_ff;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_ff <= 1'b0;
        end else if (set_in) begin
            q_ff <= 1'b1;
        end else if (clr_in) begin
            q_ff <= 1'b0;
        end
    end

    assign q_out = q_ff;
endmodule : pdr_sc_bit

// ### core/pdr_pair_map.sv
// Picks the sensed pair and the result slot for each reflectometry shot.
`timescale 1ns/1ps
module pdr_pair_map
    import pdr_pkg::*;
(
    // Setup.
    input  wire logic      cross_dis_in,
    input  wire logic      tx_byp_in,
    // Engine pair indications.
    input  wire pdr_pair_t pulse_pair_in,
    input  wire pdr_pair_t result_pair_in,
    // Mapped pairs.
    output pdr_pair_t      sense_pair_out,
    output pdr_pair_t      result_slot_out
);
    // Cross mode listens on the other pair so that pair-to-pair shorts show up.
    assign sense_pair_out  = cross_dis_in ? pulse_pair_in
                                          : pdr_pair_t'(~pulse_pair_in);
    // With the transmit pair skipped, results land in the receive slots.
    assign result_slot_out = tx_byp_in ? PAIR_RX : result_pair_in;
endmodule : pdr_pair_map

// ### core/pdr_regs.sv
// PHY power back-off, regulator power-down and cable diagnostic setup registers.
`timescale 1ns/1ps
module pdr_regs
    import pdr_pkg::*;
(
    // Clock and reset.
    input  wire logic          sys_clk_in,
    input  wire logic          rst_in,
    // Register port.
    input  wire pdr_bus_req_t  bus_in,
    output logic [DATA_W-1:0]  rdata_out,
    // Power control.
    output logic [2:0]         backoff_level_out,
    output logic               regulator_feedback_output_en_out,
    // Cable length estimator.
    output logic               est_start_out,
    output logic [2:0]         est_avg_out,
    input  wire logic          est_done_in,
    input  wire logic [7:0]    est_result_in,
    // Reflectometry setup and pair routing.
    output pdr_diag_cfg_t      diag_cfg_out,
    output logic               tx_pair_run_out,
    output logic               rx_pair_run_out,
    output logic [6:0]         avg_cycles_out,
    input  wire logic          rx_bypass_in,
    input  wire pdr_pair_t     pulse_pair_in,
    input  wire pdr_pair_t     result_pair_in,
    output pdr_pair_t          sense_pair_out,
    output pdr_pair_t          result_slot_out
);
    // Address decode.
    wire hit_bo    = bus_in.addr == OFS_BACKOFF;
    wire hit_reg   = bus_in.addr == OFS_REGULATOR;
    wire hit_est   = bus_in.addr == OFS_EST;
    wire hit_dg    = bus_in.addr == OFS_DIAG_MAIN;
    wire hit_pulse = bus_in.addr == OFS_DIAG_PULSE;
    wire wr_bo     = bus_in.wr & hit_bo;
    wire wr_reg    = bus_in.wr & hit_reg;
    wire wr_est    = bus_in.wr & hit_est;
    wire wr_dg     = bus_in.wr & hit_dg;
    wire wr_pulse  = bus_in.wr & hit_pulse;

    // Storage.
    logic [2:0]         bo_ff;
    logic [14:0]        reg_rsvd_ff;
    logic               reg_on_ff;
    logic               reg_pd_bit;
    logic [2:0]         est_avg_ff;
    logic [7:0]         est_res_ff;
    logic               est_start_ff;
    pdr_est_state_t     est_state_ff;
    pdr_est_state_t     nxt_est_state;
    pdr_diag_cfg_t      cfg_ff;
    pdr_diag_cfg_t      nxt_cfg;
    logic               keep_ff;
    logic               rx_byp_ff;
    logic               tx_run_ff;
    logic               rx_run_ff;
    logic [6:0]         avg_cyc_ff;
    logic [11:0]        pulse_rsvd_ff;
    pdr_pair_t          sense_ff;
    pdr_pair_t          slot_ff;
    pdr_pair_t          sense_map;
    pdr_pair_t          slot_map;
    logic [DATA_W-1:0]  rdata_ff;

    // Regulator power-down request bit; reads back one for a single cycle.
    wire reg_pd_req = wr_reg & bus_in.wdata[REG_PD_BIT];
    pdr_sc_bit u_reg_pd (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .set_in     (reg_pd_req),
        .clr_in     (reg_pd_bit),
        .q_out      (reg_pd_bit)
    );

    // The regulator stays down once commanded; only reset brings it back.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_on_ff <= 1'b1;
        end else if (reg_pd_req) begin
            reg_on_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bo_ff       <= BO_RST;
            reg_rsvd_ff <= REG_RSVD_RST;
        end else begin
            if (wr_bo) begin
                bo_ff <= bus_in.wdata[BO_MSB:BO_LSB];
            end
            if (wr_reg) begin
                reg_rsvd_ff <= bus_in.wdata[14:0];
            end
        end
    end

    // Length estimator run control.
    wire est_trig = wr_est & bus_in.wdata[EST_TRIG_BIT];
    wire est_busy = est_state_ff == EST_BUSY;

    always_comb begin
        nxt_est_state = est_state_ff;
        case (est_state_ff)
            EST_IDLE: begin
                if (est_trig) begin
                    nxt_est_state = EST_BUSY;
                end
            end
            EST_BUSY: begin
                if (est_done_in) begin
                    nxt_est_state = EST_IDLE;
                end
            end
            default: begin
                nxt_est_state = EST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            est_state_ff <= EST_IDLE;
            est_start_ff <= 1'b0;
            est_res_ff   <= EST_RES_RST;
            est_avg_ff   <= EST_AVG_RST;
        end else begin
            est_state_ff <= nxt_est_state;
            est_start_ff <= est_trig & ~est_busy;
            if (est_busy & est_done_in) begin
                est_res_ff <= est_result_in;
            end
            if (wr_est) begin
                est_avg_ff <= bus_in.wdata[EST_AVG_MSB:0];
            end
        end
    end

    // Reflectometry setup.
    always_comb begin
        nxt_cfg = cfg_ff;
        if (wr_dg) begin
            nxt_cfg.cross_dis = bus_in.wdata[DG_CROSS_DIS_BIT];
            nxt_cfg.tx_byp    = bus_in.wdata[DG_TX_BYP_BIT];
            nxt_cfg.avg_code  = bus_in.wdata[DG_AVG_MSB:DG_AVG_LSB];
        end
        if (wr_pulse) begin
            nxt_cfg.pulse = bus_in.wdata[PULSE_MSB:0];
        end
    end

    // The reserved averaging code runs the longest documented count.
    wire [2:0] avg_eff = (nxt_cfg.avg_code == DG_AVG_RSVD) ? DG_AVG_MAX
                                                           : nxt_cfg.avg_code;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_ff        <= '{cross_dis: 1'b0, tx_byp: 1'b0,
                               avg_code: DG_AVG_RST, pulse: PULSE_RST};
            keep_ff       <= DG_KEEP_RST;
            pulse_rsvd_ff <= PULSE_RSVD_RST;
            tx_run_ff     <= 1'b1;
            rx_run_ff     <= 1'b1;
            rx_byp_ff     <= 1'b0;
            avg_cyc_ff    <= DG_AVG_CYC_RST;
        end else begin
            cfg_ff     <= nxt_cfg;
            tx_run_ff  <= ~nxt_cfg.tx_byp;
            rx_run_ff  <= ~rx_bypass_in;
            rx_byp_ff  <= rx_bypass_in;
            avg_cyc_ff <= 7'h01 << avg_eff;
            if (wr_dg) begin
                keep_ff <= bus_in.wdata[DG_KEEP_BIT];
            end
            if (wr_pulse) begin
                pulse_rsvd_ff <= bus_in.wdata[15:4];
            end
        end
    end

    // Pair routing for each shot.
    pdr_pair_map u_pair_map (
        .cross_dis_in    (cfg_ff.cross_dis),
        .tx_byp_in       (cfg_ff.tx_byp),
        .pulse_pair_in   (pulse_pair_in),
        .result_pair_in  (result_pair_in),
        .sense_pair_out  (sense_map),
        .result_slot_out (slot_map)
    );

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sense_ff <= PAIR_RX;
            slot_ff  <= PAIR_TX;
        end else begin
            sense_ff <= sense_map;
            slot_ff  <= slot_map;
        end
    end

    // Read data; unmapped addresses read zero.
    wire [15:0] rd_bo    = BO_FIXED_RD | {7'h00, bo_ff, 6'h00};
    wire [15:0] rd_reg   = {reg_pd_bit, reg_rsvd_ff};
    wire [15:0] rd_est   = {est_busy, 3'h0, est_res_ff, 1'b0, est_avg_ff};
    wire [15:0] rd_dg    = {1'b0, cfg_ff.cross_dis, cfg_ff.tx_byp, rx_byp_ff,
                            keep_ff, cfg_ff.avg_code, 8'h00};
    wire [15:0] rd_pulse = {pulse_rsvd_ff, cfg_ff.pulse};
    wire [15:0] rd_val   = hit_bo    ? rd_bo    :
                           hit_reg   ? rd_reg   :
                           hit_est   ? rd_est   :
                           hit_dg    ? rd_dg    :
                           hit_pulse ? rd_pulse : 16'h0000;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= 16'h0000;
        end else if (bus_in.rd) begin
            rdata_ff <= rd_val;
        end
    end

    assign rdata_out                        = rdata_ff;
    assign backoff_level_out                = bo_ff;
    assign regulator_feedback_output_en_out = reg_on_ff;
    assign est_start_out                    = est_start_ff;
    assign est_avg_out                      = est_avg_ff;
    assign diag_cfg_out                     = cfg_ff;
    assign tx_pair_run_out                  = tx_run_ff;
    assign rx_pair_run_out                  = rx_run_ff;
    assign avg_cycles_out                   = avg_cyc_ff;
    assign sense_pair_out                   = sense_ff;
    assign result_slot_out                  = slot_ff;

    // Checks.
    property p_backoff_write;
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_bo |=> backoff_level_out == $past(bus_in.wdata[BO_MSB:BO_LSB]);
    endproperty
    a_backoff_write: assert property (p_backoff_write)
        else $error("Back-off level did not take the written value.");

    property p_backoff_read;
        @(posedge sys_clk_in) disable iff (rst_in)
        bus_in.rd && hit_bo |=> rdata_out[15] && rdata_out[5]
                                && rdata_out[8:6] == backoff_level_out;
    endproperty
    a_backoff_read: assert property (p_backoff_read)
        else $error("Back-off register read back wrong.");

    property p_reg_pd;
        @(posedge sys_clk_in) disable iff (rst_in)
        reg_pd_req |=> reg_pd_bit && !regulator_feedback_output_en_out
                       ##1 (reg_pd_bit == $past(reg_pd_req));
    endproperty
    a_reg_pd: assert property (p_reg_pd)
        else $error("Regulator power-down bit misbehaved.");

    property p_reg_on;
        @(posedge sys_clk_in) disable iff (rst_in)
        regulator_feedback_output_en_out && !reg_pd_req
            |=> regulator_feedback_output_en_out;
    endproperty
    a_reg_on: assert property (p_reg_on)
        else $error("Regulator turned off without a power-down write.");

    property p_est_avg;
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_est |=> est_avg_out == $past(bus_in.wdata[EST_AVG_MSB:0]);
    endproperty
    a_est_avg: assert property (p_est_avg)
        else $error("Estimator averaging factor not updated.");

    property p_est_start;
        @(posedge sys_clk_in) disable iff (rst_in)
        est_trig && !est_busy |=> est_start_out && est_busy ##1 !est_start_out;
    endproperty
    a_est_start: assert property (p_est_start)
        else $error("Estimator run did not start for one cycle.");

    property p_est_result;
        @(posedge sys_clk_in) disable iff (rst_in)
        est_busy && est_done_in |=> !est_busy
                                    && est_res_ff == $past(est_result_in);
    endproperty
    a_est_result: assert property (p_est_result)
        else $error("Estimator result not captured at run end.");

    property p_sense;
        @(posedge sys_clk_in) disable iff (rst_in)
        ##1 sense_pair_out == ($past(cfg_ff.cross_dis) ? $past(pulse_pair_in)
                               : pdr_pair_t'(~$past(pulse_pair_in)));
    endproperty
    a_sense: assert property (p_sense)
        else $error("Sensed pair does not follow cross mode.");

    property p_slot;
        @(posedge sys_clk_in) disable iff (rst_in)
        cfg_ff.tx_byp |=> result_slot_out == PAIR_RX;
    endproperty
    a_slot: assert property (p_slot)
        else $error("Bypassed transmit pair result not in receive slot.");

    property p_tx_run;
        @(posedge sys_clk_in) disable iff (rst_in)
        tx_pair_run_out == !diag_cfg_out.tx_byp;
    endproperty
    a_tx_run: assert property (p_tx_run)
        else $error("Transmit pair run disagrees with bypass bit.");

    property p_avg_cycles;
        @(posedge sys_clk_in) disable iff (rst_in)
        diag_cfg_out.avg_code != DG_AVG_RSVD
            |-> avg_cycles_out == 7'(7'h01 << diag_cfg_out.avg_code);
    endproperty
    a_avg_cycles: assert property (p_avg_cycles)
        else $error("Averaged cycle count is not two to the code.");

    property p_pulse;
        @(posedge sys_clk_in) disable iff (rst_in)
        wr_pulse |=> diag_cfg_out.pulse == $past(bus_in.wdata[PULSE_MSB:0]);
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("Pulse control not updated.");
endmodule : pdr_regs

// ### sim/pdr_regs_tb_top.sv
// Self-checking testbench for the PHY power and cable diagnostic register bank.
`timescale 1ns/1ps
module pdr_regs_tb_top
    import pdr_pkg::*;
;
    logic          sys_clk_in = 1'b0;
    logic          rst_in     = 1'b1;
    pdr_bus_req_t  bus        = '0;
    logic [15:0]   rdata;
    logic [2:0]    backoff;
    logic          reg_en;
    logic          est_start;
    logic [2:0]    est_avg;
    logic          est_done   = 1'b0;
    logic [7:0]    est_res    = 8'h00;
    pdr_diag_cfg_t cfg;
    logic          tx_run;
    logic          rx_run;
    logic [6:0]    avg_cyc;
    logic          rx_byp     = 1'b0;
    pdr_pair_t     pulse_pair = PAIR_TX;
    pdr_pair_t     res_pair   = PAIR_TX;
    pdr_pair_t     sense_pair;
    pdr_pair_t     res_slot;
    int            num_errors = 0;
    int            cmp_count  = 0;

    always #25 sys_clk_in = ~sys_clk_in;

    pdr_regs u_pdr_regs (
        .sys_clk_in                       (sys_clk_in),
        .rst_in                           (rst_in),
        .bus_in                           (bus),
        .rdata_out                        (rdata),
        .backoff_level_out                (backoff),
        .regulator_feedback_output_en_out (reg_en),
        .est_start_out                    (est_start),
        .est_avg_out                      (est_avg),
        .est_done_in                      (est_done),
        .est_result_in                    (est_res),
        .diag_cfg_out                     (cfg),
        .tx_pair_run_out                  (tx_run),
        .rx_pair_run_out                  (rx_run),
        .avg_cycles_out                   (avg_cyc),
        .rx_bypass_in                     (rx_byp),
        .pulse_pair_in                    (pulse_pair),
        .result_pair_in                   (res_pair),
        .sense_pair_out                   (sense_pair),
        .result_slot_out                  (res_slot)
    );

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic drv(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic w,
                       input logic r);
        @(posedge sys_clk_in);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : drv

    // Releases the port; the request driven before is taken at this edge.
    task automatic idle();
        @(posedge sys_clk_in);
        bus <= '0;
        @(negedge sys_clk_in);
    endtask : idle

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        drv(a, d, 1'b1, 1'b0);
        idle();
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp, input string name);
        drv(a, 16'h0000, 1'b0, 1'b1);
        idle();
        chk(name, exp, rdata);
    endtask : rd

    task automatic do_reset();
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(negedge sys_clk_in);
    endtask : do_reset

    task automatic t_reset_values();
        chk("backoff_level", 16'h0000, 16'(backoff));
        chk("est_avg", 16'h0001, 16'(est_avg));
        chk("diag_cfg", 16'h006c, 16'(cfg));
        chk("avg_cycles", 16'h0040, 16'(avg_cyc));
        chk("tx_run", 16'h0001, 16'(tx_run));
        rd(OFS_BACKOFF, 16'h8020, "backoff_rd");
        rd(OFS_REGULATOR, 16'h0000, "regulator_rd");
        rd(OFS_EST, 16'h0001, "est_rd");
        rd(OFS_DIAG_MAIN, 16'h0e00, "diag_main_rd");
        rd(OFS_DIAG_PULSE, 16'hc85c, "diag_pulse_rd");
    endtask : t_reset_values

    // Read-only bits are written as ones and must not stick.
    task automatic t_backoff();
        for (int i = 0; i < 4; i++) begin
            wr(OFS_BACKOFF, 16'hfe3f | (16'(i) << 6));
            chk("backoff_level", 16'(i), 16'(backoff));
            rd(OFS_BACKOFF, 16'h8020 | (16'(i) << 6), "backoff_rd");
        end
        wr(9'h0af, 16'h0000);
        rd(OFS_BACKOFF, 16'h80e0, "backoff_rd");
        rd(9'h0af, 16'h0000, "unmapped_rd");
    endtask : t_backoff

    task automatic t_regulator();
        wr(OFS_REGULATOR, 16'h0000);
        chk("regulator_en", 16'h0001, 16'(reg_en));
        // The bench stands for a board whose core supply is external.
        drv(OFS_REGULATOR, 16'h8000, 1'b1, 1'b0);
        drv(OFS_REGULATOR, 16'h0000, 1'b0, 1'b1);
        drv(OFS_REGULATOR, 16'h0000, 1'b0, 1'b1);
        @(negedge sys_clk_in);
        chk("regulator_pd_set", 16'h8000, rdata);
        chk("regulator_en", 16'h0000, 16'(reg_en));
        idle();
        chk("regulator_pd_clr", 16'h0000, rdata);
        repeat (20) @(negedge sys_clk_in);
        chk("regulator_en", 16'h0000, 16'(reg_en));
        do_reset();
        chk("regulator_en", 16'h0001, 16'(reg_en));
    endtask : t_regulator

    task automatic t_est();
        wr(OFS_EST, 16'h8003);
        chk("est_start", 16'h0001, 16'(est_start));
        @(negedge sys_clk_in);
        chk("est_start", 16'h0000, 16'(est_start));
        rd(OFS_EST, 16'h8003, "est_busy_rd");
        chk("est_avg", 16'h0003, 16'(est_avg));
        wr(OFS_EST, 16'h8003);
        chk("est_retrigger", 16'h0000, 16'(est_start));
        @(posedge sys_clk_in);
        est_done <= 1'b1;
        est_res  <= 8'ha5;
        @(posedge sys_clk_in);
        est_done <= 1'b0;
        est_res  <= 8'h3c;
        rd(OFS_EST, 16'h0a53, "est_result_rd");
        wr(OFS_EST, 16'h7ffa);
        rd(OFS_EST, 16'h0a52, "est_ro_rd");
        chk("est_avg", 16'h0002, 16'(est_avg));
    endtask : t_est

    // Codes 0 to 6 give two to the code cycles; the reserved code is checked too.
    task automatic t_diag();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            @(posedge sys_clk_in);
            rx_byp <= c[2];
            wr(OFS_DIAG_MAIN, {1'b1, c[0], c[1], 1'b1, 1'b1, c, 8'hff});
            rd(OFS_DIAG_MAIN, {1'b0, c[0], c[1], c[2], 1'b1, c, 8'h00}, "diag_main_rd");
            chk("cross_dis", 16'(c[0]), 16'(cfg.cross_dis));
            chk("tx_run", 16'(!c[1]), 16'(tx_run));
            chk("rx_run", 16'(!c[2]), 16'(rx_run));
            chk("avg_code", 16'(c), 16'(cfg.avg_code));
            chk("avg_cycles", (c == 3'h7) ? 16'h0040 : 16'h0001 << c, 16'(avg_cyc));
        end
    endtask : t_diag

    task automatic t_pulse();
        wr(OFS_DIAG_PULSE, 16'h3a75);
        rd(OFS_DIAG_PULSE, 16'h3a75, "diag_pulse_rd");
        chk("pulse", 16'h0005, 16'(cfg.pulse));
    endtask : t_pulse

    task automatic t_pair_map();
        logic [3:0] v;
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            wr(OFS_DIAG_MAIN, 16'h0e00 | (16'(v[1:0]) << 13));
            @(posedge sys_clk_in);
            pulse_pair <= pdr_pair_t'(v[2]);
            res_pair   <= pdr_pair_t'(v[3]);
            @(posedge sys_clk_in);
            @(negedge sys_clk_in);
            chk("sense_pair", 16'(v[1] ? v[2] : !v[2]), 16'(sense_pair));
            chk("result_slot", 16'(v[0] ? 1'b1 : v[3]), 16'(res_slot));
        end
    endtask : t_pair_map

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        num_errors++;
        stop_test();
    end

    initial begin
        do_reset();
        t_reset_values();
        t_backoff();
        t_regulator();
        t_est();
        t_diag();
        t_pulse();
        t_pair_map();
        stop_test();
    end

endmodule : pdr_regs_tb_top
